// [src/servo_speed_loop_controller.v]
// Speed loop controller: PI on speed error, derivative on feedback.
// Assumes sample_strobe_i pulses once per control sample, all inputs synchronous.
//
// What this block does
// R1 - Torque from P, I on error, D feedback
// R2 - Selector 0 first gains, 1 second
// R3 - Selector change applies while enabled or disabled
// R4 - Zero integral gain gives proportional plus D feedback
// R5 - Integral accumulates error, scaled by gain
// R6 - Derivative on filtered feedback, limits noise
// R7 - Tuning code 0 manual, 1 bandwidth, 2 compliance
// R8 - Bandwidth mode computes proportional, integral gains
// R9 - Compliance mode computes proportional, integral gains
// R10 - Operator tunes proportional then integral manually
// R11 - Inertia measurement result stored as inertia
// R12 - Recompute on input change, apply next sample
`timescale 1ns/1ps
`include "speed_loop_regs.vh"

module servo_speed_loop_controller (
  input  wire        ref_clk_i,
  input  wire        reset_i,
  input  wire        sample_strobe_i,
  input  wire [15:0] speed_reference_i,
  input  wire [15:0] speed_feedback_i,
  input  wire        drive_enable_i,
  input  wire        gain_set_selector_i,
  input  wire [15:0] first_set_proportional_gain_i,
  input  wire [15:0] first_set_integral_gain_i,
  input  wire [15:0] first_set_derivative_gain_i,
  input  wire [15:0] second_set_proportional_gain_i,
  input  wire [15:0] second_set_integral_gain_i,
  input  wire [15:0] second_set_derivative_gain_i,
  input  wire [1:0]  tuning_method_select_i,
  input  wire [15:0] target_loop_bandwidth_i,
  input  wire [15:0] target_compliance_angle_i,
  input  wire [15:0] target_damping_factor_i,
  input  wire [15:0] torque_per_amp_setting_i,
  input  wire        combined_inertia_write_i,
  input  wire [15:0] combined_inertia_data_i,
  input  wire        inertia_meas_done_i,
  input  wire        inertia_meas_ok_i,
  input  wire [15:0] accel_time_i,
  input  wire [15:0] decel_time_i,
  output reg  [15:0] torque_demand_o,
  output reg         torque_valid_o,
  output reg  [15:0] combined_inertia_o,
  output reg  [15:0] proportional_gain_o,
  output reg  [15:0] integral_gain_o,
  output reg  [15:0] derivative_gain_o,
  output reg         gain_calc_busy_o
);

  reg  signed [23:0] acc_q;
  reg  signed [15:0] fb_filt_q;
  wire        [15:0] calc_kp;
  wire        [15:0] calc_ki;
  wire               calc_busy;
  reg         [15:0] set_kp;
  reg         [15:0] set_ki;
  reg         [15:0] set_kd;
  reg         [15:0] kp;
  reg         [15:0] ki;

  function [15:0] sat16s;
    input signed [47:0] v;
    begin
      if (v > 48'sh000000007fff)
        sat16s = 16'h7fff;
      else if (v < -48'sh000000008000)
        sat16s = 16'h8000;
      else
        sat16s = v[15:0];
    end
  endfunction

  function [23:0] sat24s;
    input signed [24:0] v;
    begin
      if (v > $signed({1'b0, `ACC_MAX}))
        sat24s = `ACC_MAX;
      else if (v < $signed({1'b1, `ACC_MIN}))
        sat24s = `ACC_MIN;
      else
        sat24s = v[23:0];
    end
  endfunction

  // Sign extension shared by all 17-bit differences
  function [16:0] sext17;
    input [15:0] v;
    begin
      sext17 = {v[15], v};
    end
  endfunction

  // R7 calculated gains only in modes 1 and 2
  speed_gain_calc u_gain_calc (
    .ref_clk_i                 (ref_clk_i),
    .reset_i                   (reset_i),
    .tuning_method_select_i    (tuning_method_select_i),
    .target_loop_bandwidth_i   (target_loop_bandwidth_i),
    .target_compliance_angle_i (target_compliance_angle_i),
    .target_damping_factor_i   (target_damping_factor_i),
    .motor_torque_constant_i   (torque_per_amp_setting_i),
    .combined_inertia_i        (combined_inertia_o),
    .calc_kp_o                 (calc_kp),
    .calc_ki_o                 (calc_ki),
    .calc_busy_o               (calc_busy)
  );

  // R2 pick the active set
  // R3 selector read live every sample, no disable needed
  always @* begin
    case (gain_set_selector_i)
      `GAIN_SET_SECOND: begin
        set_kp = second_set_proportional_gain_i;
        set_ki = second_set_integral_gain_i;
        set_kd = second_set_derivative_gain_i;
      end
      default: begin
        set_kp = first_set_proportional_gain_i;
        set_ki = first_set_integral_gain_i;
        set_kd = first_set_derivative_gain_i;
      end
    endcase
  end

  // R7 code 0 and spare code 3 keep written gains
  // R8 calculated gains replace the set's P and I
  // R9 same path for compliance angle
  // Old calculated I gain stays in use until a new calculation ends; the new P gain applies once its step finishes
  always @* begin
    case (tuning_method_select_i)
      `TUNE_BANDWIDTH, `TUNE_COMPLIANCE: begin
        kp = calc_kp;
        ki = calc_ki;
      end
      default: begin
        kp = set_kp;
        ki = set_ki;
      end
    endcase
  end

  wire [15:0] kd         = set_kd;

  // R1 speed error
  wire signed [16:0] err = $signed(sext17(speed_reference_i)) -
                           $signed(sext17(speed_feedback_i));

  // R5 accumulate with clamp; clamp stops windup at saturation
  wire signed [24:0] acc_sum  = {acc_q[23], acc_q} + {{8{err[16]}}, err};
  wire signed [23:0] acc_next = sat24s(acc_sum);

  // R6 first-order filter on feedback keeps quantisation noise out of D
  wire signed [16:0] fb_diff  = $signed(sext17(speed_feedback_i)) -
                                $signed(sext17(fb_filt_q));
  wire signed [16:0] fb_step  = fb_diff >>> `FILT_SHIFT;
  wire signed [16:0] filt_sum = $signed(sext17(fb_filt_q)) + fb_step;
  wire signed [15:0] filt_next = filt_sum[15:0];
  wire signed [16:0] deriv    = $signed(sext17(filt_next)) - $signed(sext17(fb_filt_q));

  // R4 with ki zero the integral product is zero
  wire signed [33:0] p_term = $signed({1'b0, kp}) * err;
  wire signed [40:0] i_prod = $signed({1'b0, ki}) * acc_next;
  wire signed [40:0] i_term = i_prod >>> `INT_SHIFT;
  wire signed [33:0] d_term = $signed({1'b0, kd}) * deriv;

  // R1 sum; derivative subtracts since it opposes feedback motion
  wire signed [47:0] sum = {{14{p_term[33]}}, p_term} + {{7{i_term[40]}}, i_term} -
                           {{14{d_term[33]}}, d_term};
  wire signed [47:0] sum_sc = sum >>> `OUT_SHIFT;

  // R11 inertia from measured ramp times
  wire [16:0] ramp_sum   = {1'b0, accel_time_i} + {1'b0, decel_time_i};
  wire [32:0] inertia_pr = torque_per_amp_setting_i * ramp_sum;
  wire [32:0] inertia_sc = inertia_pr >> `INERTIA_SHIFT;
  wire [15:0] inertia_meas = (|inertia_sc[32:16]) ? 16'hffff : inertia_sc[15:0];

  // Torque, gains and filter move only on a strobe
  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      acc_q               <= `ACC_RST;
      fb_filt_q           <= 16'sh0000;
      torque_demand_o     <= `TORQUE_RST;
      torque_valid_o      <= 1'b0;
      proportional_gain_o <= `GAIN_RST;
      integral_gain_o     <= `GAIN_RST;
      derivative_gain_o   <= `GAIN_RST;
      gain_calc_busy_o    <= 1'b0;
    end else begin
      torque_valid_o   <= 1'b0;
      gain_calc_busy_o <= calc_busy;
      // R12 gains sampled at each control sample
      if (sample_strobe_i) begin
        fb_filt_q           <= filt_next;
        proportional_gain_o <= kp;
        integral_gain_o     <= ki;
        derivative_gain_o   <= kd;
        torque_valid_o      <= 1'b1;
        if (drive_enable_i) begin
          acc_q           <= acc_next;
          torque_demand_o <= sat16s(sum_sc);
        end else begin
          // Disabled drive holds no integral history
          acc_q           <= `ACC_RST;
          torque_demand_o <= `TORQUE_RST;
        end
      end
    end
  end

  // R11 measurement wins over a user write
  // Done without ok loads no measurement; a user write in the same cycle still applies
  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      combined_inertia_o <= `INERTIA_RST;
    end else if (inertia_meas_done_i && inertia_meas_ok_i) begin
      combined_inertia_o <= inertia_meas;
    end else if (combined_inertia_write_i) begin
      combined_inertia_o <= combined_inertia_data_i;
    end
  end

endmodule // servo_speed_loop_controller

// [src/speed_loop_regs.vh]
// Constants for the servo speed loop controller and its gain calculator.
// Assumes fixed-point Q formats as noted; included by bare name.
`ifndef SPEED_LOOP_REGS_VH
`define SPEED_LOOP_REGS_VH

// Tuning method codes
`define TUNE_MANUAL      2'h0
`define TUNE_BANDWIDTH   2'h1
`define TUNE_COMPLIANCE  2'h2

// Gain set selector codes
`define GAIN_SET_FIRST   1'h0
`define GAIN_SET_SECOND  1'h1

// Reset values
`define GAIN_RST         16'h0000
`define INERTIA_RST      16'h0100
`define ACC_RST          24'h000000
`define TORQUE_RST       16'h0000

// Integral accumulator limits, signed 24-bit
`define ACC_MAX          24'h7fffff
`define ACC_MIN          24'h800000

// Fixed-point shifts
`define FILT_SHIFT       3
`define INT_SHIFT        8
`define OUT_SHIFT        8
`define DAMP_FRAC        8
`define WSQ_SHIFT        8
`define KP_SCALE         1
`define INERTIA_SHIFT    4

// Compliance angle to bandwidth conversion numerator
`define COMPL_NUM        32'h00010000

// Divider iteration count
`define DIV_STEPS        6'h20
`define DIV_LAST         6'h1f

`endif

// [src/speed_gain_calc.v]
// Gain calculator: derives proportional and integral gains from targets.
// Assumes inputs are held stable by the caller; recomputes in modes 1 and 2 when an input it uses changes.
`timescale 1ns/1ps
`include "speed_loop_regs.vh"

module speed_gain_calc (
  input  wire        ref_clk_i,
  input  wire        reset_i,
  input  wire [1:0]  tuning_method_select_i,
  input  wire [15:0] target_loop_bandwidth_i,
  input  wire [15:0] target_compliance_angle_i,
  input  wire [15:0] target_damping_factor_i,
  input  wire [15:0] motor_torque_constant_i,
  input  wire [15:0] combined_inertia_i,
  output reg  [15:0] calc_kp_o,
  output reg  [15:0] calc_ki_o,
  output reg         calc_busy_o
);

  localparam [3:0] ST_IDLE  = 4'h1;
  localparam [3:0] ST_DIV_W = 4'h2;
  localparam [3:0] ST_KP    = 4'h4;
  localparam [3:0] ST_KI    = 4'h8;

  reg [3:0]  state_q;
  reg [79:0] snap_q;
  reg [15:0] w_q;
  reg [31:0] num_q;
  reg [16:0] rem_q;
  reg [31:0] quo_q;
  reg [5:0]  cnt_q;

  wire [79:0] snap_now = {tuning_method_select_i == `TUNE_COMPLIANCE ?
                          target_compliance_angle_i : target_loop_bandwidth_i,
                          target_damping_factor_i, motor_torque_constant_i,
                          combined_inertia_i, {14'h0000, tuning_method_select_i}};
  wire        calc_mode = (tuning_method_select_i == `TUNE_BANDWIDTH) ||
                          (tuning_method_select_i == `TUNE_COMPLIANCE);
  wire [15:0] divisor   = (state_q == ST_DIV_W) ? snap_q[79:64] : snap_q[47:32];
  wire [16:0] rem_sh    = {rem_q[15:0], num_q[31]};
  wire        take      = rem_sh >= {1'b0, divisor};
  wire [31:0] quo_next  = {quo_q[30:0], take};

  function [31:0] sat32;
    input [47:0] v;
    sat32 = (|v[47:32]) ? 32'hffffffff : v[31:0];
  endfunction

  function [15:0] sat16u;
    input [31:0] v;
    sat16u = (|v[31:16]) ? 16'hffff : v[15:0];
  endfunction

  // Damping times bandwidth times inertia, doubled
  wire [31:0] zw     = snap_q[63:48] * w_q;
  wire [47:0] kp_raw = {24'h000000, zw[31:`DAMP_FRAC]} * {32'h00000000, snap_q[31:16]};
  // Bandwidth squared times inertia
  wire [31:0] ww     = w_q * w_q;
  wire [47:0] ki_raw = {24'h000000, ww[31:`WSQ_SHIFT]} * {32'h00000000, snap_q[31:16]};

  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      state_q     <= ST_IDLE;
      snap_q      <= 80'h0;
      w_q         <= 16'h0000;
      num_q       <= 32'h00000000;
      rem_q       <= 17'h00000;
      quo_q       <= 32'h00000000;
      cnt_q       <= 6'h00;
      calc_kp_o   <= `GAIN_RST;
      calc_ki_o   <= `GAIN_RST;
      calc_busy_o <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          // R12 restart on change
          if (calc_mode && snap_now != snap_q) begin
            snap_q      <= snap_now;
            calc_busy_o <= 1'b1;
            rem_q       <= 17'h00000;
            quo_q       <= 32'h00000000;
            cnt_q       <= 6'h00;
            // R9 angle to bandwidth
            if (tuning_method_select_i == `TUNE_COMPLIANCE) begin
              num_q   <= `COMPL_NUM;
              state_q <= ST_DIV_W;
            end else begin
              w_q     <= snap_now[79:64];
              state_q <= ST_KP;
            end
          end
        end
        ST_DIV_W, ST_KP, ST_KI: begin
          // First cycle of a gain state loads its numerator
          if (cnt_q == 6'h00 && state_q != ST_DIV_W && num_q == 32'h00000000 &&
              quo_q == 32'h00000000) begin
            num_q <= (state_q == ST_KP) ? sat32(kp_raw << `KP_SCALE) : sat32(ki_raw);
            cnt_q <= 6'h01;
          end else begin
            num_q <= {num_q[30:0], 1'b0};
            rem_q <= take ? rem_sh - {1'b0, divisor} : rem_sh;
            quo_q <= quo_next;
            cnt_q <= cnt_q + 6'h01;
            if (cnt_q == `DIV_LAST + ((state_q == ST_DIV_W) ? 6'h00 : 6'h01)) begin
              rem_q <= 17'h00000;
              quo_q <= 32'h00000000;
              num_q <= 32'h00000000;
              cnt_q <= 6'h00;
              // R8 gains from bandwidth
              case (state_q)
                ST_DIV_W: begin
                  w_q     <= sat16u(quo_next);
                  state_q <= ST_KP;
                end
                ST_KP: begin
                  calc_kp_o <= sat16u(quo_next);
                  state_q   <= ST_KI;
                end
                default: begin
                  calc_ki_o   <= sat16u(quo_next);
                  calc_busy_o <= 1'b0;
                  state_q     <= ST_IDLE;
                end
              endcase
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

endmodule // speed_gain_calc

// [dv/speed_loop_monitor.sv]
// Port checker for the speed loop controller.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
module speed_loop_monitor (
  input logic        ref_clk_i,
  input logic        reset_i,
  input logic        sample_strobe_i,
  input logic        drive_enable_i,
  input logic        gain_set_selector_i,
  input logic [15:0] first_set_derivative_gain_i,
  input logic [15:0] second_set_derivative_gain_i,
  input logic        combined_inertia_write_i,
  input logic [15:0] combined_inertia_data_i,
  input logic        inertia_meas_done_i,
  input logic        inertia_meas_ok_i,
  input logic [15:0] torque_demand_o,
  input logic        torque_valid_o,
  input logic [15:0] combined_inertia_o,
  input logic [15:0] derivative_gain_o,
  input logic        gain_calc_busy_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  a_valid_follows: assert property (
    sample_strobe_i |=> torque_valid_o) else $error("no valid after strobe");
  a_valid_only: assert property (
    !sample_strobe_i |=> !torque_valid_o) else $error("valid without strobe");
  a_torque_holds: assert property (
    !sample_strobe_i |=> $stable(torque_demand_o)) else $error("torque moved");
  a_disabled_zero: assert property (
    sample_strobe_i && !drive_enable_i |=> torque_demand_o == 16'h0000)
    else $error("torque while disabled");
  a_first_deriv: assert property (
    sample_strobe_i && !gain_set_selector_i
    |=> derivative_gain_o == $past(first_set_derivative_gain_i)) else $error("set 0 gain");
  a_second_deriv: assert property (
    sample_strobe_i && gain_set_selector_i
    |=> derivative_gain_o == $past(second_set_derivative_gain_i)) else $error("set 1 gain");
  a_inertia_refused: assert property (
    inertia_meas_done_i && !inertia_meas_ok_i && !combined_inertia_write_i
    |=> $stable(combined_inertia_o)) else $error("failed measurement loaded");
  a_inertia_write: assert property (
    combined_inertia_write_i && !inertia_meas_done_i
    |=> combined_inertia_o == $past(combined_inertia_data_i)) else $error("write lost");
  a_calc_bounded: assert property (
    $rose(gain_calc_busy_o) |-> ##[1:200] !gain_calc_busy_o) else $error("calc hung");
endmodule // speed_loop_monitor
bind servo_speed_loop_controller speed_loop_monitor mon (.*);

// [dv/motor_speed_model.sv]
// Behavioural load: speed feedback integrates the torque demand.
// Assumes the controller pulses valid once per sample.
`timescale 1ns/1ps
module motor_speed_model (
  input  logic        ref_clk_i,
  input  logic        reset_i,
  input  logic        torque_valid_i,
  input  logic [15:0] torque_demand_i,
  output logic [15:0] speed_feedback_o
);
  // Torque/16 per sample keeps the speed swing small
  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      speed_feedback_o <= 16'h0000;
    end else if (torque_valid_i) begin
      speed_feedback_o <= speed_feedback_o + {{4{torque_demand_i[15]}}, torque_demand_i[15:4]};
    end
  end
endmodule // motor_speed_model

// [dv/servo_speed_loop_controller_bench.sv]
// Self-checking bench for the speed loop controller.
// Assumes the load model in motor_speed_model closes the loop.
`timescale 1ns/1ps
module servo_speed_loop_controller_bench;
  logic               clk = 1'b0;
  logic               rst = 1'b1;
  logic               strobe = 1'b0;
  logic               enable = 1'b1;
  logic               sel = 1'b0;
  logic               iwr = 1'b0;
  logic               done = 1'b0;
  logic               ok = 1'b0;
  logic [1:0]         mode = 2'h0;
  logic [15:0]        g [0:5];
  logic [15:0]        sref = 16'h0000;
  logic [15:0]        bw = 16'h0040;
  logic [15:0]        ang = 16'h0100;
  logic [15:0]        zeta = 16'h0100;
  logic [15:0]        kt = 16'h0010;
  logic [15:0]        idata = 16'h0000;
  logic [15:0]        tacc = 16'h0000;
  logic [15:0]        tdec = 16'h0000;
  logic [15:0]        jval = 16'h0100;
  logic [15:0]        ckp = 16'h0000;
  logic [15:0]        cki = 16'h0000;
  logic [63:0]        w;
  logic [31:0]        seed = 32'h1d7a79be;
  logic signed [63:0] acc_m = 0;
  logic signed [63:0] filt_m = 0;
  wire  [15:0]        fb, torque, inertia, kp_o, ki_o, kd_o;
  wire                valid, busy;
  int                 fail_count = 0;
  int                 comparisons = 0;

  motor_speed_model load (.ref_clk_i(clk), .reset_i(rst), .torque_valid_i(valid),
    .torque_demand_i(torque), .speed_feedback_o(fb));
  servo_speed_loop_controller dut (.ref_clk_i(clk), .reset_i(rst), .sample_strobe_i(strobe),
    .speed_reference_i(sref), .speed_feedback_i(fb), .drive_enable_i(enable),
    .gain_set_selector_i(sel), .first_set_proportional_gain_i(g[0]),
    .first_set_integral_gain_i(g[1]), .first_set_derivative_gain_i(g[2]),
    .second_set_proportional_gain_i(g[3]), .second_set_integral_gain_i(g[4]),
    .second_set_derivative_gain_i(g[5]), .tuning_method_select_i(mode),
    .target_loop_bandwidth_i(bw), .target_compliance_angle_i(ang),
    .target_damping_factor_i(zeta), .torque_per_amp_setting_i(kt),
    .combined_inertia_write_i(iwr), .combined_inertia_data_i(idata),
    .inertia_meas_done_i(done), .inertia_meas_ok_i(ok), .accel_time_i(tacc),
    .decel_time_i(tdec), .torque_demand_o(torque), .torque_valid_o(valid),
    .combined_inertia_o(inertia), .proportional_gain_o(kp_o), .integral_gain_o(ki_o),
    .derivative_gain_o(kd_o), .gain_calc_busy_o(busy));

  initial forever #25 clk = ~clk;

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic signed [63:0] clip(input logic signed [63:0] v, input int b);
    logic signed [63:0] m;
    m = 64'sd1 <<< (b - 1);
    return (v >= m) ? m - 1 : (v < -m) ? -m : v;
  endfunction
  function automatic logic [15:0] usat(input logic [63:0] v);
    return (v > 64'hffff) ? 16'hffff : v[15:0];
  endfunction
  function automatic logic [15:0] gain(input logic [63:0] w, input bit p);
    if (kt == 16'h0000) return 16'hffff;
    if (p) return usat((((zeta * w) >> 8) * jval * 2) / kt);
    return usat((((w * w) >> 8) * jval) / kt);
  endfunction

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Strobe held high when keep is set, so samples run back to back
  task automatic sample(input bit keep);
    logic signed [63:0] err, fn, t, e;
    logic [15:0] kp, ki, kd;
    kp = (mode == 2'h1 || mode == 2'h2) ? ckp : (sel ? g[3] : g[0]);
    ki = (mode == 2'h1 || mode == 2'h2) ? cki : (sel ? g[4] : g[1]);
    kd = sel ? g[5] : g[2];
    err = $signed(sref) - $signed(fb);
    fn = filt_m + (($signed(fb) - filt_m) >>> 3);
    acc_m = enable ? clip(acc_m + err, 24) : 0;
    t = $signed({48'h0, kp}) * err + (($signed({48'h0, ki}) * acc_m) >>> 8);
    t = t - $signed({48'h0, kd}) * (fn - filt_m);
    filt_m = fn;
    e = enable ? clip(t >>> 8, 16) : 0;
    if (!strobe) strobe = 1'b1;
    @(negedge clk);
    if (!keep) strobe = 1'b0;
    check("valid", {15'h0, valid}, 16'h0001);
    check("torque", torque, e[15:0]);
    check("kd", kd_o, kd);
    check("kp", kp_o, kp);
    check("ki", ki_o, ki);
    if (!keep) begin
      @(negedge clk);
      check("valid low", {15'h0, valid}, 16'h0000);
    end
  endtask
  task automatic wait_calc;
    int n;
    n = 0;
    repeat (4) @(negedge clk);
    while (busy !== 1'b0 && n < 300) begin
      @(negedge clk);
      n++;
    end
    check("calc busy", {15'h0, busy}, 16'h0000);
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    final_report;
  end

  initial begin
    int i;
    for (i = 0; i < 6; i++) g[i] = 16'h0010;
    repeat (12) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    check("reset torque", torque, 16'h0000);
    check("reset inertia", inertia, 16'h0100);
    check("reset kp", kp_o, 16'h0000);
    $display("reset test done");
    // written gains set as an operator would
    for (i = 0; i < 25; i++) begin
      seed = lfsr(seed);
      sref = {{5{seed[10]}}, seed[10:0]};
      g[i % 6] = (i < 6 && i % 3 == 1) ? 16'h0000 : {8'h0, seed[23:16]};
      mode = seed[24] ? 2'h3 : 2'h0;
      if (i % 4 == 3) sel = ~sel;
      sample(i % 5 != 4);
    end
    $display("manual gain test done");
    idata = 16'h0234;
    iwr = 1'b1;
    @(negedge clk);
    iwr = 1'b0;
    jval = idata;
    tacc = 16'h0100;
    tdec = 16'h0080;
    done = 1'b1;
    @(negedge clk);
    done = 1'b0;
    check("inertia write", inertia, jval);
    @(negedge clk);
    check("inertia kept", inertia, jval);
    {done, ok, iwr, idata} = {3'h7, 16'h1111};
    @(negedge clk);
    {done, ok, iwr} = 3'h0;
    jval = usat(({48'h0, kt} * ({48'h0, tacc} + tdec)) >> 4);
    @(negedge clk);
    check("inertia measured", inertia, jval);
    $display("inertia test done");
    for (i = 1; i < 3; i++) begin
      mode = i[1:0];
      bw = bw + 16'h0010;
      wait_calc;
      w = (i == 1) ? {48'h0, bw} : {48'h0, usat(64'h10000 / ang)};
      ckp = gain(w, 1);
      cki = gain(w, 0);
      sample(0);
      zeta = zeta + 16'h0040;
      wait_calc;
      ckp = gain(w, 1);
      sample(0);
    end
    $display("calculated gain test done");
    enable = 1'b0;
    sample(0);
    sel = ~sel;
    sample(0);
    $display("disable test done");
    final_report;
  end
endmodule // servo_speed_loop_controller_bench
